/* File: dpt_cfg.svh */
// Constants of the drive parameter telegram master: offsets, fields, timing.
// Assumes byte addresses on a 32-bit APB bus, one register per word.
`ifndef DPT_CFG_SVH
`define DPT_CFG_SVH
// ----------------------------------------
// Telegram framing
// ----------------------------------------
`define DPT_START_BYTE     8'h02
`define DPT_PARAM_LEN      8'h0E
`define DPT_LAST_IDX       5'h0F
`define DPT_FIRST_DATA     5'h03
`define DPT_RSP_FAULT      4'h7
`define DPT_CMD_READ       4'h1
`define DPT_CMD_TEXT       4'hF
`define DPT_TEXT_RD_HI     8'h04
`define DPT_TEXT_WR_HI     8'h05
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPT_REQ_ADDR       8'h00
`define DPT_REQ_KEY        8'h04
`define DPT_REQ_INDEX      8'h08
`define DPT_REQ_VALUE      8'h0C
`define DPT_REQ_PCD        8'h10
`define DPT_CTRL           8'h14
`define DPT_STATUS         8'h18
`define DPT_RSP_KEY        8'h1C
`define DPT_RSP_VALUE      8'h20
`define DPT_RSP_PCD        8'h24
`define DPT_RSP_ADDR       8'h28
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DPT_CTRL_GO        0
`define DPT_CTRL_TEXT_WR   1
`define DPT_ST_BUSY        0
`define DPT_ST_DONE        1
`define DPT_ST_ERR         2
`define DPT_ST_TMO         3
`define DPT_ST_FAULT       4
`define DPT_ST_BCAST       5
`define DPT_RST_WORD       32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define DPT_CLK_NS         100
`define DPT_REPLY_TMO_NS   50000000
`endif

/* File: dpt_pkg.sv */
// Types shared by the telegram master and its reply parser.
// Assumes the constants of dpt_cfg.svh.
package dpt_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] key;
        logic [15:0] index;
        logic [31:0] value;
        logic [31:0] process_words;
    } dpt_tel_s;

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_SEND = 3'b010,
        M_WAIT = 3'b100
    } dpt_mstate_e;

    typedef enum logic [2:0] {
        R_HUNT = 3'b001,
        R_LEN  = 3'b010,
        R_BODY = 3'b100
    } dpt_rstate_e;

    // Both address formats: 1-31 with bit 5 flag, 1-126 with zero address
    function automatic logic isBroadcast(input logic [7:0] a);
        isBroadcast = a[7] ? (a[6:0] == 7'h00) : a[5];
    endfunction : isBroadcast

endpackage : dpt_pkg

/* File: dpt_rx_parser.sv */
// Reply parser: frames reply bytes, checks the XOR checksum, captures fields.
// Assumes one received byte per rxValid pulse from a separate receiver.
`timescale 1ns/1ns
`include "dpt_cfg.svh"
module dpt_rx_parser
    import dpt_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       arm,
    input  wire logic       rxValid,
    input  wire logic [7:0] rxData,
    output logic            repDone,
    output logic            repErr,
    output dpt_tel_s        rep
);
    dpt_rstate_e state_q;
    logic [7:0]  bcc_q;
    logic [7:0]  len_q;
    logic [7:0]  pos_q;
    logic [7:0]  dIdx;
    logic        lastByte;

    assign dIdx     = pos_q - 8'h01;
    assign lastByte = (state_q == R_BODY) && rxValid && (pos_q == len_q - 8'h01);

    // ----------------------------------------
    // Framing and checksum
    // ----------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n || arm)
        begin
            state_q <= R_HUNT;
            bcc_q   <= 8'h00;
            len_q   <= 8'h00;
            pos_q   <= 8'h00;
            repDone <= 1'b0;
            repErr  <= 1'b0;
        end
        else
        begin
            repDone <= 1'b0;
            repErr  <= 1'b0;
            if (rxValid)
            begin
                case (state_q)
                    R_HUNT:
                    begin
                        // Stray bytes before a start byte are dropped
                        if (rxData == `DPT_START_BYTE) // see RULE1
                        begin
                            bcc_q   <= rxData; // see RULE2
                            state_q <= R_LEN;
                        end
                    end
                    R_LEN:
                    begin
                        bcc_q   <= bcc_q ^ rxData;
                        len_q   <= rxData; // see RULE13
                        pos_q   <= 8'h00;
                        state_q <= (rxData < 8'h02) ? R_HUNT : R_BODY;
                        repErr  <= (rxData < 8'h02);
                    end
                    R_BODY:
                    begin
                        bcc_q <= bcc_q ^ rxData;
                        pos_q <= pos_q + 8'h01;
                        if (lastByte)
                        begin
                            repDone <= (bcc_q == rxData); // see RULE2
                            repErr  <= (bcc_q != rxData);
                            state_q <= R_HUNT;
                        end
                    end
                    default: state_q <= R_HUNT;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Field capture
    // ----------------------------------------
    // Process words are the last four data bytes, whatever the length
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rep <= '0;
        else if (state_q == R_BODY && rxValid && !lastByte)
        begin
            if (pos_q == 8'h00)
                rep.addr <= rxData; // see RULE27
            else
            begin
                if (dIdx == 8'h00)
                    rep.key[15:8] <= rxData; // see RULE3
                else if (dIdx == 8'h01)
                    rep.key[7:0] <= rxData;
                else if (dIdx == 8'h02)
                    rep.index[15:8] <= rxData;
                else if (dIdx == 8'h03)
                    rep.index[7:0] <= rxData;
                else if (dIdx < 8'h08)
                    rep.value <= {rep.value[23:0], rxData}; // see RULE7
                rep.process_words <= {rep.process_words[23:0], rxData}; // see RULE20
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cbr @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_rx_bad_bcc: assert property (lastByte && !arm && bcc_q != rxData |=> repErr && !repDone) // see RULE2
        else $error("checksum mismatch not flagged");
    a_rx_needs_stx: assert property (state_q == R_HUNT && rxValid && rxData != `DPT_START_BYTE && !arm
        |=> state_q == R_HUNT) // see RULE1
        else $error("parser left hunt without start byte");

endmodule : dpt_rx_parser

/* File: dpt_master.sv */
// Telegram master: builds parameter-block queries for a drive slave and
// checks its replies; software reaches it over APB.
// Assumes a byte transmitter with valid/ready and a byte receiver strobe.
//
// Functional notes
// RULE1 - Start, length, address, data, checksum byte order
// RULE2 - Checksum is XOR of bytes, from zero
// RULE3 - Key top nibble: command out, response back
// RULE4 - Slave answers 0111 with fault number
// RULE5 - Key low twelve bits: parameter number
// RULE6 - Slave uses only index low byte
// RULE7 - Value field four bytes, meaning per command
// RULE8 - Read request sends empty value field
// RULE9 - Write request carries new value field
// RULE10 - Slave returns current value on read
// RULE11 - Option parameters written by ordinal number
// RULE12 - Only text-type parameters readable as text
// RULE13 - Text telegram length from length byte
// RULE14 - Text read: command F, index high 4
// RULE15 - Text write: command F, index high 5
// RULE16 - Slave decodes the listed data type codes
// RULE17 - Values are integers scaled by conversion factor
// RULE18 - Slave maps conversion indices to factors
// RULE19 - Unsigned types carry no sign
// RULE20 - Process data: two words, fixed order
// RULE21 - Slave only answers, never initiates
// RULE22 - No reply to broadcast address
// RULE23 - Query carries address, action, data, check
// RULE24 - Reply confirms action, data, check
// RULE25 - Bad query: error reply or silence
// RULE26 - Bytes move one per valid strobe
// RULE27 - Slave echoes received address byte
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "dpt_cfg.svh"
module dpt_master
    import dpt_pkg::*;
#(
    parameter int unsigned TimeoutCycles = `DPT_REPLY_TMO_NS / `DPT_CLK_NS
)
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txValid,
    input  wire logic        txReady,
    output logic [7:0]       txData,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxData
);
    dpt_mstate_e state_q;
    dpt_tel_s    cfg_q;
    dpt_tel_s    req_q;
    dpt_tel_s    rep;
    logic        textWr_q;
    logic [4:0]  txIdx_q;
    logic [7:0]  bcc_q;
    logic [7:0]  bccNext;
    logic [31:0] tmo_q;
    logic        done_q;
    logic        err_q;
    logic        tmoFlag_q;
    logic        fault_q;
    logic        bcast_q;
    logic        repDone;
    logic        repErr;
    logic        apbWr;
    logic        go;
    logic        lastSent;
    logic        addrOk;
    logic [31:0] rdMux;
    logic [15:0] goIndex;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Read data is latched in the setup cycle so prdata comes from a flop
    assign pready  = 1'b1;
    assign apbWr   = psel && penable && pwrite;
    assign go      = apbWr && paddr == `DPT_CTRL && pwdata[`DPT_CTRL_GO] && state_q == M_IDLE;
    assign pslverr = psel && penable && !addrOk;

    always_comb
    begin
        addrOk = 1'b1;
        rdMux  = `DPT_RST_WORD;
        if (paddr == `DPT_REQ_ADDR)
            rdMux = {24'h0, cfg_q.addr};
        else if (paddr == `DPT_REQ_KEY)
            rdMux = {16'h0, cfg_q.key};
        else if (paddr == `DPT_REQ_INDEX)
            rdMux = {16'h0, cfg_q.index};
        else if (paddr == `DPT_REQ_VALUE)
            rdMux = cfg_q.value;
        else if (paddr == `DPT_REQ_PCD)
            rdMux = cfg_q.process_words;
        else if (paddr == `DPT_CTRL)
            rdMux = {30'h0, textWr_q, 1'b0};
        else if (paddr == `DPT_STATUS)
            rdMux = {26'h0, bcast_q, fault_q, tmoFlag_q, err_q, done_q, state_q != M_IDLE};
        else if (paddr == `DPT_RSP_KEY)
            rdMux = {rep.index, rep.key};
        else if (paddr == `DPT_RSP_VALUE)
            rdMux = rep.value;
        else if (paddr == `DPT_RSP_PCD)
            rdMux = rep.process_words;
        else if (paddr == `DPT_RSP_ADDR)
            rdMux = {24'h0, rep.addr};
        else
            addrOk = 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            prdata <= `DPT_RST_WORD;
        else if (psel && !penable)
            prdata <= rdMux;
    end

    // Request fields are free to change while a telegram is in flight
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cfg_q    <= '0;
            textWr_q <= 1'b0;
        end
        else if (apbWr)
        begin
            if (paddr == `DPT_REQ_ADDR)
                cfg_q.addr <= pwdata[7:0];
            else if (paddr == `DPT_REQ_KEY)
                cfg_q.key <= pwdata[15:0]; // see RULE5
            else if (paddr == `DPT_REQ_INDEX)
                cfg_q.index <= pwdata[15:0];
            else if (paddr == `DPT_REQ_VALUE)
                cfg_q.value <= pwdata; // see RULE9 see RULE11 see RULE17 see RULE19
            else if (paddr == `DPT_REQ_PCD)
                cfg_q.process_words <= pwdata;
            else if (paddr == `DPT_CTRL)
                textWr_q <= pwdata[`DPT_CTRL_TEXT_WR];
        end
    end

    // ----------------------------------------
    // Query snapshot
    // ----------------------------------------
    always_comb
    begin
        goIndex = cfg_q.index;
        // Bit written with GO
        if (cfg_q.key[15:12] == `DPT_CMD_TEXT) // see RULE14 see RULE15
            goIndex[15:8] = pwdata[`DPT_CTRL_TEXT_WR] ? `DPT_TEXT_WR_HI : `DPT_TEXT_RD_HI;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            req_q <= '0;
        else if (go)
        begin
            req_q       <= cfg_q;
            req_q.index <= goIndex;
            if (cfg_q.key[15:12] == `DPT_CMD_READ)
                req_q.value <= 32'h0000_0000; // see RULE8
        end
    end

    // Byte i of the telegram, checksum position excluded
    function automatic logic [7:0] telByte(input dpt_tel_s r, input logic [4:0] i);
        logic [95:0] dw;
        int          k;
        dw = {r.key, r.index, r.value, r.process_words};
        k  = int'(i) - 3;
        if (i == 5'h00)
            telByte = `DPT_START_BYTE;
        else if (i == 5'h01)
            telByte = `DPT_PARAM_LEN;
        else if (i == 5'h02)
            telByte = r.addr;
        else
            telByte = dw[(11 - k) * 8 +: 8];
    endfunction : telByte

    // ----------------------------------------
    // Transmit sequencer
    // ----------------------------------------
    assign txValid  = (state_q == M_SEND); // see RULE26
    assign bccNext  = bcc_q ^ txData;
    assign lastSent = txValid && txReady && txIdx_q == `DPT_LAST_IDX;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_q <= M_IDLE;
            txIdx_q <= 5'h00;
            txData  <= 8'h00;
            bcc_q   <= 8'h00;
            tmo_q   <= 32'h0;
        end
        else
        begin
            case (state_q)
                M_IDLE:
                begin
                    if (go)
                    begin
                        state_q <= M_SEND;
                        txIdx_q <= 5'h00;
                        txData  <= `DPT_START_BYTE; // see RULE1
                        bcc_q   <= 8'h00; // see RULE2
                    end
                end
                M_SEND:
                begin
                    if (txReady)
                    begin
                        bcc_q   <= bccNext;
                        txIdx_q <= txIdx_q + 5'h01;
                        if (txIdx_q == `DPT_LAST_IDX)
                            state_q <= isBroadcast(req_q.addr) ? M_IDLE : M_WAIT; // see RULE22
                        else if (txIdx_q + 5'h01 == `DPT_LAST_IDX)
                            txData <= bccNext; // see RULE23
                        else
                            txData <= telByte(req_q, txIdx_q + 5'h01);
                        tmo_q <= 32'h0;
                    end
                end
                M_WAIT:
                begin
                    // One query outstanding until reply, bad reply or timeout
                    tmo_q <= tmo_q + 32'h1;
                    if (repDone || repErr || tmo_q == TimeoutCycles - 1) // see RULE21 see RULE25
                        state_q <= M_IDLE;
                end
                default: state_q <= M_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Reply checking and status
    // ----------------------------------------
    dpt_rx_parser u_rx (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .arm     (go),
        .rxValid (rxValid && state_q == M_WAIT),
        .rxData  (rxData),
        .repDone (repDone),
        .repErr  (repErr),
        .rep     (rep)
    );

    // Flags clear on reset and on go, and go is never in a cycle that sets them
    always_ff @(posedge mclk)
    begin
        if (!rst_n || go)
        begin
            done_q    <= 1'b0;
            err_q     <= 1'b0;
            tmoFlag_q <= 1'b0;
            fault_q   <= 1'b0;
            bcast_q   <= 1'b0;
        end
        else
        begin
            if (lastSent && isBroadcast(req_q.addr))
            begin
                done_q  <= 1'b1;
                bcast_q <= 1'b1;
            end
            if (state_q == M_WAIT)
            begin
                if (repDone && rep.addr == req_q.addr) // see RULE27 see RULE24
                begin
                    done_q  <= 1'b1;
                    fault_q <= (rep.key[15:12] == `DPT_RSP_FAULT); // see RULE4 see RULE3
                end
                else if (repDone || repErr)
                    err_q <= 1'b1;
                else if (tmo_q == TimeoutCycles - 1)
                    tmoFlag_q <= 1'b1; // see RULE25
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cbm @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence sLaunch;
        go ##1 txValid && txData == `DPT_START_BYTE;
    endsequence

    sequence sLength;
        txValid && txReady && txIdx_q == 5'h00 ##1 txData == `DPT_PARAM_LEN;
    endsequence

    a_tx_first_byte: assert property (go |-> sLaunch) // see RULE1
        else $error("telegram did not open with start byte");
    a_tx_len_byte: assert property (state_q == M_SEND && txIdx_q == 5'h00 && txReady |-> sLength) // see RULE13
        else $error("length byte missing after start byte");
    a_tx_hold_byte: assert property (txValid && !txReady |=> txValid && $stable(txData)) // see RULE26
        else $error("byte changed while not accepted");
    a_read_zero_val: assert property (txValid && req_q.key[15:12] == `DPT_CMD_READ
        && txIdx_q >= 5'h07 && txIdx_q <= 5'h0A |-> txData == 8'h00) // see RULE8
        else $error("read query carried a value");
    a_bcast_no_wait: assert property (lastSent && isBroadcast(req_q.addr)
        |=> state_q == M_IDLE && done_q && bcast_q) // see RULE22
        else $error("broadcast query waited for a reply");
    a_wait_silent: assert property (state_q == M_WAIT |-> !txValid) // see RULE21
        else $error("master sent while awaiting reply");
    a_fault_flag: assert property (state_q == M_WAIT && repDone && rep.addr == req_q.addr
        && rep.key[15:12] == `DPT_RSP_FAULT |=> fault_q && done_q && state_q == M_IDLE) // see RULE4
        else $error("fault reply not reported");
    a_timeout_end: assert property (state_q == M_WAIT && tmo_q == TimeoutCycles - 1 && !repDone
        && !repErr |=> tmoFlag_q && state_q == M_IDLE) // see RULE25
        else $error("reply timeout not reported");

endmodule : dpt_master

/* File: dpt_drive_model.sv */
// Behavioural drive slave answering 16-byte parameter queries.
// Assumes a byte link on mclk: txValid/txReady in, rxValid strobes out.
`timescale 1ns/1ns
module dpt_drive_model
    import dpt_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       slow,
    input  wire logic       badSum,
    input  wire logic       mute,
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic [7:0] txData,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            protoErr
);
    logic [127:0] sh;
    logic [127:0] rsh;
    logic [119:0] body;
    logic [31:0]  store [16];
    logic [4:0]   qn;
    logic [4:0]   rn;
    logic         got;
    logic         tick;
    logic         bc;
    logic [31:0]  rv;
    logic [15:0]  rk;
    dpt_tel_s     q;

    function automatic logic [7:0] xsum(input logic [119:0] v);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 15; i++)
            s ^= v[i*8 +: 8];
        return s;
    endfunction : xsum

    assign q    = sh[111:8];
    assign bc   = q.addr[7] ? (q.addr[6:0] == 7'h00) : q.addr[5];
    assign body = {16'h020E, q.addr, rk, q.index, rv, ~q.process_words[31:16], q.process_words[15:0]};

    always_comb
    begin
        rk = {4'h2, q.key[11:0]};
        rv = (q.key[15:12] == 4'h1) ? store[q.key[3:0]] : q.value;
        if (q.key[11:4] != 8'h00)
        begin
            rk = {4'h7, q.key[11:0]};
            rv = 32'h0;
        end
        if (q.key[15:12] == 4'hF)
        begin
            // No text-typed parameters here, so every text access is refused
            rk = {4'h7, q.key[11:0]};
            rv = 32'h5;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            qn       <= 5'h0;
            rn       <= 5'h0;
            got      <= 1'b0;
            tick     <= 1'b0;
            txReady  <= 1'b0;
            rxValid  <= 1'b0;
            rxData   <= 8'h00;
            protoErr <= 1'b0;
        end
        else
        begin
            tick    <= ~tick;
            txReady <= !slow || tick;
            got     <= txValid && txReady && qn == 5'hF;
            if (txValid && txReady)
            begin
                sh <= {sh[119:0], txData};
                qn <= (qn == 5'hF) ? 5'h0 : qn + 5'h1;
            end
            if (got)
            begin
                if (sh[127:112] != 16'h020E || sh[7:0] != xsum(sh[127:8])
                    || (q.key[15:12] == 4'h1 && q.value != 32'h0)
                    || (q.key[15:12] == 4'hF && q.index[15:9] != 7'h02))
                    protoErr <= 1'b1;
                if (q.key[15:12] inside {4'h2, 4'h3, 4'hD, 4'hE} && rk[15:12] == 4'h2)
                    store[q.key[3:0]] <= q.value;
                rsh <= {body, xsum(body) ^ {7'h00, badSum}};
                rn  <= (bc || mute) ? 5'h0 : 5'h10;
            end
            rxValid <= 1'b0;
            // Idle line inverts the stale byte every cycle, so it never holds it for two cycles
            rxData  <= ~rxData;
            if (rn != 5'h0 && tick)
            begin
                rxValid <= 1'b1;
                rxData  <= rsh[127:120];
                rsh     <= rsh << 8;
                rn      <= rn - 5'h1;
            end
        end
    end
endmodule : dpt_drive_model

/* File: drive_param_telegram_codec_bench.sv */
// Self-checking bench: table of queries through APB, then edge cases.
// Assumes dpt_drive_model on the byte link and a short reply timeout.
`timescale 1ns/1ns
`include "dpt_cfg.svh"
module drive_param_telegram_codec_bench;
    import dpt_pkg::*;

    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] k;
        logic [15:0] ix;
        logic [31:0] v;
        logic        tw;
        logic [15:0] ek;
        logic [15:0] ei;
        logic [31:0] ev;
        logic [31:0] es;
    } dpt_row_s;

    logic        mclk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        txValid;
    logic        txReady;
    logic [7:0]  txData;
    logic        rxValid;
    logic [7:0]  rxData;
    logic        slow;
    logic        badSum;
    logic        mute;
    logic        protoErr;
    int          mismatches = 0;
    int          samplesChecked = 0;
    int          cyc = 0;
    int          rxCount = 0;
    logic [7:0]  bcast [2] = '{8'h3F, 8'h80};
    dpt_row_s    rows [9] = '{
        '{8'h85, 16'h2003, 16'h0, 32'h3E8, 1'b0, 16'h2003, 16'h0, 32'h3E8, 32'h2},
        '{8'h85, 16'h1003, 16'h0, 32'hFFFF_FFFF, 1'b0, 16'h2003, 16'h0, 32'h3E8, 32'h2},
        '{8'h0A, 16'h300F, 16'h0, 32'h8000_0001, 1'b0, 16'h200F, 16'h0, 32'h8000_0001, 32'h2},
        '{8'h0A, 16'h100F, 16'h107, 32'h0, 1'b0, 16'h200F, 16'h107, 32'h8000_0001, 32'h2},
        '{8'h85, 16'h1010, 16'h0, 32'h0, 1'b0, 16'h7010, 16'h0, 32'h0, 32'h12},
        '{8'h85, 16'hF0FF, 16'h12, 32'h0, 1'b0, 16'h70FF, 16'h412, 32'h5, 32'h12},
        '{8'h85, 16'hF0FF, 16'h12, 32'h0, 1'b1, 16'h70FF, 16'h512, 32'h5, 32'h12},
        '{8'hFE, 16'hE005, 16'h0, 32'h7, 1'b0, 16'h2005, 16'h0, 32'h7, 32'h2},
        '{8'h81, 16'hD006, 16'h0, 32'h1234_5678, 1'b0, 16'h2006, 16'h0, 32'h1234_5678, 32'h2}};

    dpt_master #(.TimeoutCycles(200)) u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txValid(txValid), .txReady(txReady),
        .txData(txData), .rxValid(rxValid), .rxData(rxData));
    dpt_drive_model u_drive (.mclk(mclk), .rst_n(rst_n), .slow(slow), .badSum(badSum),
        .mute(mute), .txValid(txValid), .txReady(txReady), .txData(txData),
        .rxValid(rxValid), .rxData(rxData), .protoErr(protoErr));

    // ----------------------------------------
    // Clock, hang guard, bus tasks
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc++;
        if (rxValid === 1'b1)
            rxCount++;
        if (cyc == 20000)
        begin
            mismatches++;
            endOfTest();
        end
    end

    task automatic endOfTest;
        $display("checks=%0d mismatches=%0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : endOfTest

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samplesChecked++;
        if (g !== x)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Waits on pready; only the hang guard ends a stuck slave
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask : rdc

    task automatic send(input dpt_row_s t, input logic [31:0] p);
        logic [31:0] r;
        logic        e;
        wr(`DPT_REQ_ADDR, {24'h0, t.a});
        wr(`DPT_REQ_KEY, {16'h0, t.k});
        wr(`DPT_REQ_INDEX, {16'h0, t.ix});
        wr(`DPT_REQ_VALUE, t.v);
        wr(`DPT_REQ_PCD, p);
        wr(`DPT_CTRL, {30'h0, t.tw, 1'b1});
        r = 32'h1;
        while (r[0] !== 1'b0)
            apb(1'b0, `DPT_STATUS, 32'h0, r, e);
    endtask : send

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] r;
        logic        e;
        dpt_row_s    t;
        int          n;
        rst_n   = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        slow    = 1'b0;
        badSum  = 1'b0;
        mute    = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rdc(`DPT_STATUS, 32'h0);
        rdc(`DPT_RSP_VALUE, 32'h0);
        apb(1'b0, 8'h40, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            slow <= i[0];
            send(rows[i], 32'h047F_0000 | i);
            rdc(`DPT_STATUS, rows[i].es);
            rdc(`DPT_RSP_KEY, {rows[i].ei, rows[i].ek});
            rdc(`DPT_RSP_VALUE, rows[i].ev);
            rdc(`DPT_RSP_PCD, {16'hFB80, i[15:0]});
            rdc(`DPT_RSP_ADDR, {24'h0, rows[i].a});
        end
        foreach (bcast[j])
        begin
            t   = rows[0];
            t.a = bcast[j];
            n   = rxCount;
            send(t, 32'h0);
            rdc(`DPT_STATUS, 32'h22);
            chk(rxCount, n);
        end
        badSum <= 1'b1;
        send(rows[1], 32'h0);
        apb(1'b0, `DPT_STATUS, 32'h0, r, e);
        chk(r & 32'h4, 32'h4);
        badSum <= 1'b0;
        mute   <= 1'b1;
        send(rows[1], 32'h0);
        apb(1'b0, `DPT_STATUS, 32'h0, r, e);
        chk(r & 32'h8, 32'h8);
        chk({31'h0, protoErr}, 32'h0);
        endOfTest();
    end
endmodule : drive_param_telegram_codec_bench
